// ### ifam_core.sv
// Function
// R01 - maskable interrupts are blocked at enable 0 and allowed at 1.
// R02 - acknowledging an interrupt clears the enable flag to 0.
// R03 - stack select 0 picks the interrupt stack pointer, 1 the user one.
// R04 - stack select clears on hardware interrupts and software ones 0 to 31.
// R05 - the priority level is three bits holding 0 to 7.
// R06 - a request is taken only if its priority is strictly above the level.
// R07 - reserved flag bits read undefined and software writes them as 0.
// R08 - the decoder spans one megabyte, addresses 00000h to FFFFFh.
// R09 - program memory ends at 0FFFFh, so 16 kilobytes start at 0C000h.
// R10 - 0FFDCh to 0FFFFh holds the vector table read on interrupt entry.
// R11 - data flash decodes at 02400h to 02BFFh.
// R12 - internal RAM starts at 00400h, so one kilobyte ends at 007FFh.
// R13 - 00000h to 002FFh goes to the peripheral control region.
// R14 - software must not touch unassigned peripheral control locations.
// R15 - a low level on the reset input resets the whole block.
// R16 - 16 registers exist, in two banks of seven plus the two stack pointers.
// R17 - interrupt and call stack data go to RAM at the selected pointer; the code pushes interrupt entries at the interrupt stack pointer.
`timescale 1ns/100ps
`default_nettype none

module ifam_core
    import ifam_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire ifam_irq_t         i_irq,
    input  wire logic              i_swi,
    input  wire logic [VEC_W-1:0]  i_swi_num,
    input  wire logic              i_flags_wr,
    input  wire ifam_flags_t       i_flags_wdata,
    input  wire logic              i_bank_sel,
    input  wire logic              i_reg_wr,
    input  wire logic [2:0]        i_reg_idx,
    input  wire logic [15:0]       i_reg_wdata,
    input  wire logic              i_sp_wr,
    input  wire logic [15:0]       i_sp_wdata,
    input  wire logic              i_push,
    input  wire ifam_bus_t         i_bus,
    output logic                   o_irq_ack,
    output logic                   o_vec_fetch,
    output ifam_flags_t            o_flags,
    output logic [15:0]            o_interrupt_stack_pointer,
    output logic [15:0]            o_user_stack_pointer,
    output logic [15:0]            o_stack_addr,
    output logic                   o_stack_wr,
    output logic [15:0]            o_reg_rdata,
    output ifam_region_t           o_region,
    output logic                   o_pcr_sel,
    output logic                   o_ram_sel,
    output logic                   o_dflash_sel,
    output logic                   o_rom_sel,
    output logic                   o_vec_sel,
    output logic                   o_unmapped
);

    logic        ien_q;
    logic        ssel_q;
    logic [2:0]  cpu_priority_level_q;
    logic [15:0] interrupt_stack_pointer_q;
    logic [15:0] user_stack_pointer_q;
    logic [15:0] bank_q [NUM_BANKS][REGS_PER_BANK];
    logic        irq_take;
    logic        swi_low;
    logic [15:0] sel_sp;

    default clocking cb_core @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    function automatic ifam_region_t decode(input logic [19:0] a);
        if (a <= PCR_HI)                                      // R13
            decode = REGION_PCR;
        else if (a >= RAM_LO && a < RAM_LO + RAM_SIZE)        // R12
            decode = REGION_RAM;
        else if (a >= DFLASH_LO && a <= DFLASH_HI)            // R11
            decode = REGION_DFLASH;
        else if (a >= VEC_LO && a <= VEC_HI)                  // R10
            decode = REGION_VEC;
        else if (a > ROM_HI - ROM_SIZE && a <= ROM_HI)        // R09
            decode = REGION_ROM;
        else
            decode = REGION_NONE;                             // R08
    endfunction

    // request accepted only when enabled and strictly above level
    assign irq_take = i_irq.valid && ien_q
                      && (i_irq.prio > cpu_priority_level_q);  // R01 R06
    assign swi_low  = i_swi && (i_swi_num <= SWI_SEL_MAX);
    assign sel_sp   = (ssel_q == SSEL_ISP) ? interrupt_stack_pointer_q
                                           : user_stack_pointer_q;  // R03

    // enable flag; acknowledge wins over a software write
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ien_q <= IEN_RST;                                  // R15
        else if (irq_take)
            ien_q <= 1'b0;                                     // R02
        else if (i_flags_wr)
            ien_q <= i_flags_wdata.ien;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ssel_q <= SSEL_RST;
        else if (irq_take || swi_low)
            ssel_q <= SSEL_ISP;                                // R04
        else if (i_flags_wr)
            ssel_q <= i_flags_wdata.ssel;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            cpu_priority_level_q <= IPL_RST;
        else if (irq_take)
            cpu_priority_level_q <= i_irq.prio;                // R05
        else if (i_flags_wr)
            cpu_priority_level_q <= i_flags_wdata.cpu_priority_level;         // R05
    end

    // selected stack pointer writes and pushes; interrupt entry lowers the interrupt stack pointer unless a stack pointer write in the same cycle wins
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            interrupt_stack_pointer_q <= SP_RST;
            user_stack_pointer_q      <= SP_RST;
        end
        else if (i_sp_wr)
        begin
            if (ssel_q == SSEL_ISP)
                interrupt_stack_pointer_q <= i_sp_wdata;       // R03
            else
                user_stack_pointer_q <= i_sp_wdata;            // R03
        end
        else if (irq_take || i_push)
        begin
            if (irq_take || ssel_q == SSEL_ISP)
                interrupt_stack_pointer_q <= interrupt_stack_pointer_q
                                             - 16'h0002;
            else
                user_stack_pointer_q <= user_stack_pointer_q - 16'h0002;
        end
    end

    // push address into ram at the selected pointer, or at the interrupt stack pointer on interrupt entry
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_stack_addr <= SP_RST;
            o_stack_wr   <= 1'b0;
        end
        else
        begin
            o_stack_wr   <= irq_take || i_push;                 // R17
            o_stack_addr <= (irq_take ? interrupt_stack_pointer_q : sel_sp)
                            - 16'h0002;                        // R17
        end
    end

    // two banks of seven registers plus two stack pointers make 16 regs
    genvar gb;
    genvar gr;
    generate
        for (gb = 0; gb < NUM_BANKS; gb++)
        begin : g_bank
            for (gr = 0; gr < REGS_PER_BANK; gr++)
            begin : g_reg
                always_ff @(posedge i_clk or negedge i_nrst)
                begin
                    if (!i_nrst)
                        bank_q[gb][gr] <= REG_RST;
                    else if (i_reg_wr && i_bank_sel == 1'(gb)
                             && i_reg_idx == 3'(gr))
                        bank_q[gb][gr] <= i_reg_wdata;         // R16
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_reg_rdata <= REG_RST;
        else if (i_reg_idx < 3'(REGS_PER_BANK))
            o_reg_rdata <= bank_q[i_bank_sel][i_reg_idx];
        else
            o_reg_rdata <= REG_RST;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_irq_ack   <= 1'b0;
            o_vec_fetch <= 1'b0;
        end
        else
        begin
            o_irq_ack   <= irq_take;                           // R06
            o_vec_fetch <= irq_take;                           // R10
        end
    end

    // flags mirror; reserved bits are not carried
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_flags                   <= '0;  // R07
            o_interrupt_stack_pointer <= SP_RST;
            o_user_stack_pointer      <= SP_RST;
        end
        else
        begin
            o_flags.ien               <= irq_take   ? 1'b0 :
                                         i_flags_wr ? i_flags_wdata.ien :
                                                      ien_q;
            o_flags.ssel              <= ssel_q;
            o_flags.cpu_priority_level               <= cpu_priority_level_q;
            o_interrupt_stack_pointer <= interrupt_stack_pointer_q;
            o_user_stack_pointer      <= user_stack_pointer_q;
        end
    end

    // registered address decode
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_region     <= REGION_NONE;
            o_pcr_sel    <= 1'b0;
            o_ram_sel    <= 1'b0;
            o_dflash_sel <= 1'b0;
            o_rom_sel    <= 1'b0;
            o_vec_sel    <= 1'b0;
            o_unmapped   <= 1'b0;
        end
        else
        begin
            o_region     <= i_bus.valid ? decode(i_bus.addr) : REGION_NONE;
            o_pcr_sel    <= i_bus.valid && decode(i_bus.addr) == REGION_PCR;
            o_ram_sel    <= i_bus.valid && decode(i_bus.addr) == REGION_RAM;
            o_dflash_sel <= i_bus.valid && decode(i_bus.addr) == REGION_DFLASH;
            o_rom_sel    <= i_bus.valid && (decode(i_bus.addr) == REGION_ROM
                            || decode(i_bus.addr) == REGION_VEC);  // R09
            o_vec_sel    <= i_bus.valid && decode(i_bus.addr) == REGION_VEC;
            o_unmapped   <= i_bus.valid && decode(i_bus.addr) == REGION_NONE;
        end
    end

    // interrupt entry: take, then ack, vector fetch and push
    sequence seq_irq_take;
        irq_take;
    endsequence

    sequence seq_irq_entry;
        o_irq_ack && o_vec_fetch && o_stack_wr
            && o_stack_addr == $past(interrupt_stack_pointer_q) - 16'h0002;
    endsequence

    AST_BLOCK_WHEN_OFF: assert property ( // R01
        !ien_q |=> !o_irq_ack)
        else $error("ack while disabled");

    AST_ACK_CLEARS_IEN: assert property ( // R02
        o_irq_ack |-> !ien_q && !o_flags.ien)
        else $error("enable not cleared");

    AST_ACK_CLEARS_SSEL: assert property ( // R04
        o_irq_ack |-> !ssel_q)
        else $error("stack select not cleared");

    AST_SWI_CLEARS_SSEL: assert property ( // R04
        swi_low |=> !ssel_q)
        else $error("swi kept user stack");

    AST_SWI_HIGH_KEEPS: assert property ( // R04
        (i_swi && i_swi_num > SWI_SEL_MAX && !irq_take && !i_flags_wr)
        |=> ssel_q == $past(ssel_q))
        else $error("high swi changed stack select");

    AST_PRIO_STRICT: assert property ( // R06
        o_irq_ack |-> $past(i_irq.prio) > $past(cpu_priority_level_q))
        else $error("priority not above level");

    AST_LOW_PRIO_REFUSED: assert property ( // R06
        (i_irq.valid && ien_q && i_irq.prio <= cpu_priority_level_q)
        |=> !o_irq_ack)
        else $error("low priority taken");

    AST_LEVEL_TAKEN: assert property ( // R05
        o_irq_ack |-> cpu_priority_level_q == $past(i_irq.prio))
        else $error("level not raised");

    AST_SP_WRITE_ISP: assert property ( // R03
        (i_sp_wr && ssel_q == SSEL_ISP)
        |=> interrupt_stack_pointer_q == $past(i_sp_wdata))
        else $error("interrupt stack write missed");

    AST_SP_WRITE_USP: assert property ( // R03
        (i_sp_wr && ssel_q == SSEL_USP)
        |=> user_stack_pointer_q == $past(i_sp_wdata))
        else $error("user stack write missed");

    AST_ISP_DECREMENT: assert property ( // R17
        (irq_take && !i_sp_wr) |=> interrupt_stack_pointer_q
            == $past(interrupt_stack_pointer_q) - 16'h0002)
        else $error("interrupt stack not lowered");

    AST_STACK_PUSH: assert property ( // R17
        seq_irq_take |=> seq_irq_entry)
        else $error("no stack write");

    AST_PCR_RANGE: assert property ( // R13
        (i_bus.valid && i_bus.addr == PCR_HI) |=> o_pcr_sel)
        else $error("pcr top missed");

    AST_PCR_END: assert property ( // R13
        (i_bus.valid && i_bus.addr == 20'h00300) |=> !o_pcr_sel && o_unmapped)
        else $error("pcr overrun");

    AST_RAM_RANGE: assert property ( // R12
        (i_bus.valid && i_bus.addr == 20'h007ff) |=> o_ram_sel)
        else $error("ram top missed");

    AST_VEC_RANGE: assert property ( // R10
        (i_bus.valid && i_bus.addr == 20'h0ffdc) |=> o_vec_sel && o_rom_sel)
        else $error("vector decode");

    AST_DFLASH_BASE: assert property ( // R11
        (i_bus.valid && i_bus.addr == DFLASH_LO) |=> o_dflash_sel)
        else $error("data flash base missed");

    AST_DFLASH_RANGE: assert property ( // R11
        (i_bus.valid && i_bus.addr == 20'h02c00) |=> !o_dflash_sel)
        else $error("data flash overrun");

    AST_ROM_BASE: assert property ( // R09
        (i_bus.valid && i_bus.addr == 20'h0c000) |=> o_rom_sel)
        else $error("rom base missed");

    AST_UNMAPPED_TOP: assert property ( // R08
        (i_bus.valid && i_bus.addr == SPACE_HI)
        |=> o_unmapped && o_region == REGION_NONE)
        else $error("top of space decoded");

    AST_BANK_WRITE: assert property ( // R16
        (i_reg_wr && i_reg_idx < 3'(REGS_PER_BANK))
        |=> bank_q[$past(i_bank_sel)][$past(i_reg_idx)]
            == $past(i_reg_wdata))
        else $error("bank write lost");

endmodule // ifam_core

`default_nettype wire

// ### ifam_irq_src.sv
`timescale 1ns/100ps
`default_nettype none

module ifam_irq_src
    import ifam_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_raise,
    input  wire logic       i_drop,
    input  wire logic [2:0] i_prio,
    input  wire logic       i_ack,
    output var  ifam_irq_t  o_irq
);
    logic       pend_q;
    logic [2:0] prio_q;

    // level request held until acknowledged or withdrawn
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pend_q <= 1'h0;
            prio_q <= 3'h0;
        end
        else
        begin
            if (i_raise)
                prio_q <= i_prio;
            if (i_ack || i_drop)
                pend_q <= 1'h0;
            else if (i_raise)
                pend_q <= 1'h1;
        end
    end

    // idle priority lines show the inverse, never a stale match
    always_comb
    begin
        o_irq.valid = pend_q;
        o_irq.prio  = pend_q ? prio_q : ~prio_q;
    end
endmodule // ifam_irq_src

`default_nettype wire

// ### ifam_pkg.sv
package ifam_pkg;

    localparam int          ADDR_W          = 20;
    localparam int          IPL_W           = 3;
    localparam int          SP_W            = 16;
    localparam int          DATA_W          = 16;
    localparam int          VEC_W           = 8;
    localparam int          NUM_BANKS       = 2;
    localparam int          REGS_PER_BANK   = 7;
    localparam int          REG_IDX_W       = 3;

    localparam logic [19:0] SPACE_LO        = 20'h00000;
    localparam logic [19:0] SPACE_HI        = 20'hfffff;
    localparam logic [19:0] PCR_LO          = 20'h00000;
    localparam logic [19:0] PCR_HI          = 20'h002ff;
    localparam logic [19:0] RAM_LO          = 20'h00400;
    localparam logic [19:0] RAM_SIZE        = 20'h00400;
    localparam logic [19:0] DFLASH_LO       = 20'h02400;
    localparam logic [19:0] DFLASH_HI       = 20'h02bff;
    localparam logic [19:0] ROM_HI          = 20'h0ffff;
    localparam logic [19:0] ROM_SIZE        = 20'h04000;
    localparam logic [19:0] VEC_LO          = 20'h0ffdc;
    localparam logic [19:0] VEC_HI          = 20'h0ffff;

    localparam logic [7:0]  SWI_SEL_MAX     = 8'h1f;
    localparam logic        IEN_RST         = 1'h0;
    localparam logic        SSEL_RST        = 1'h0;
    localparam logic [2:0]  IPL_RST         = 3'h0;
    localparam logic [15:0] SP_RST          = 16'h0000;
    localparam logic [15:0] REG_RST         = 16'h0000;
    localparam logic        SSEL_ISP        = 1'h0;
    localparam logic        SSEL_USP        = 1'h1;

    typedef enum logic [2:0]
    {
        REGION_NONE,
        REGION_PCR,
        REGION_RAM,
        REGION_DFLASH,
        REGION_ROM,
        REGION_VEC
    } ifam_region_t;

    typedef struct packed
    {
        logic        ien;
        logic        ssel;
        logic [2:0]  cpu_priority_level;
    } ifam_flags_t;

    typedef struct packed
    {
        logic        valid;
        logic [2:0]  prio;
    } ifam_irq_t;

    typedef struct packed
    {
        logic        valid;
        logic [19:0] addr;
    } ifam_bus_t;

endpackage

// ### tb_interrupt_flags_address_map.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %h exp %h", $time, a, e); end end

module tb_interrupt_flags_address_map;
    import ifam_pkg::*;
    logic         clk, nrst, swi, fwr, bsel, rwr, spwr, push, raise, drop;
    logic [7:0]   swn;
    logic [2:0]   ridx, prio;
    logic [15:0]  rwd, spd, interrupt_stack_pointer, user_stack_pointer, sa, rd;
    logic         ack, vf, swr;
    logic [5:0]   sel;
    ifam_flags_t  fw, fl;
    ifam_bus_t    bus;
    ifam_irq_t    irq;
    ifam_region_t rg;
    int           miscompares, comparisons, k, b, i, n;
    logic [28:0]  rows [14] = '{
        {20'h00004, 6'h20, REGION_PCR}, {20'h002ff, 6'h20, REGION_PCR},
        {20'h00300, 6'h01, REGION_NONE}, {20'h00400, 6'h10, REGION_RAM},
        {20'h007ff, 6'h10, REGION_RAM}, {20'h00800, 6'h01, REGION_NONE},
        {20'h02400, 6'h08, REGION_DFLASH}, {20'h02bff, 6'h08, REGION_DFLASH},
        {20'h02c00, 6'h01, REGION_NONE}, {20'h0c000, 6'h04, REGION_ROM},
        {20'h0ffdb, 6'h04, REGION_ROM}, {20'h0ffdc, 6'h06, REGION_VEC},
        {20'h0ffff, 6'h06, REGION_VEC}, {20'hfffff, 6'h01, REGION_NONE}};

    ifam_core u_dut (.i_clk(clk), .i_nrst(nrst), .i_irq(irq), .i_swi(swi),
        .i_swi_num(swn), .i_flags_wr(fwr), .i_flags_wdata(fw),
        .i_bank_sel(bsel), .i_reg_wr(rwr), .i_reg_idx(ridx),
        .i_reg_wdata(rwd), .i_sp_wr(spwr), .i_sp_wdata(spd), .i_push(push),
        .i_bus(bus), .o_irq_ack(ack), .o_vec_fetch(vf), .o_flags(fl),
        .o_interrupt_stack_pointer(interrupt_stack_pointer), .o_user_stack_pointer(user_stack_pointer),
        .o_stack_addr(sa), .o_stack_wr(swr), .o_reg_rdata(rd),
        .o_region(rg), .o_pcr_sel(sel[5]), .o_ram_sel(sel[4]),
        .o_dflash_sel(sel[3]), .o_rom_sel(sel[2]), .o_vec_sel(sel[1]),
        .o_unmapped(sel[0]));
    ifam_irq_src u_src (.i_clk(clk), .i_nrst(nrst), .i_raise(raise),
        .i_drop(drop), .i_prio(prio), .i_ack(ack), .o_irq(irq));

    task tick; @(negedge clk); endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick;
        s = 1'h0;
        tick;
    endtask
    task report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #100000 miscompares++;
        report_and_stop;
    end

    initial
    begin
        {nrst, swi, fwr, bsel, rwr, spwr, push, raise, drop} = '0;
        {swn, ridx, prio, rwd, spd} = '0;
        fw = '0;
        bus = '0;
        repeat (6) tick;
        `CHK(fl, 5'h00)
        `CHK(rg, REGION_NONE)
        nrst = 1'h1;
        tick;
        $display("test reset done");
        foreach (rows[k])
        begin
            bus = '{1'h1, rows[k][28:9]};
            tick;
            `CHK(rg, ifam_region_t'(rows[k][2:0]))
            `CHK(sel, rows[k][8:3])
        end
        bus.valid = 1'h0;
        $display("test decode done");
        fw = 5'h00;
        pulse(fwr);
        spd = 16'h0800;
        pulse(spwr);
        `CHK(interrupt_stack_pointer, 16'h0800)
        fw = 5'h08;
        pulse(fwr);
        spd = 16'h07f0;
        pulse(spwr);
        `CHK(user_stack_pointer, 16'h07f0)
        `CHK(interrupt_stack_pointer, 16'h0800)
        push = 1'h1;
        tick;
        push = 1'h0;
        `CHK(swr, 1'h1)
        `CHK(sa, 16'h07ee)
        tick;
        `CHK(user_stack_pointer, 16'h07ee)
        $display("test stack done");
        fw = 5'h1b;
        pulse(fwr);
        `CHK(fl, 5'h1b)
        prio = 3'h3;
        raise = 1'h1;
        tick;
        raise = 1'h0;
        repeat (4)
        begin
            tick;
            `CHK(ack, 1'h0)
        end
        pulse(drop);
        fw = 5'h0f;
        pulse(fwr);
        `CHK(fl, 5'h0f)
        fw = 5'h08;
        pulse(fwr);
        prio = 3'h7;
        pulse(raise);
        repeat (4)
        begin
            tick;
            `CHK(ack, 1'h0)
        end
        fw = 5'h18;
        fwr = 1'h1;
        tick;
        fwr = 1'h0;
        n = 0;
        while (ack !== 1'h1 && n < 8)
        begin
            tick;
            n++;
        end
        `CHK(ack, 1'h1)
        `CHK(vf, 1'h1)
        `CHK(swr, 1'h1)
        `CHK(sa, 16'h07fe)
        `CHK(fl.ien, 1'h0)
        tick;
        `CHK(ack, 1'h0)
        `CHK(fl, 5'h07)
        `CHK(interrupt_stack_pointer, 16'h07fe)
        $display("test interrupt done");
        for (k = 0; k < 2; k++)
        begin
            fw = 5'h08;
            pulse(fwr);
            swn = k[0] ? 8'h20 : 8'h1f;
            pulse(swi);
            `CHK(fl.ssel, k[0])
        end
        $display("test swi done");
        for (b = 0; b < 2; b++)
            for (i = 0; i < 7; i++)
            begin
                bsel = b[0];
                ridx = i[2:0];
                rwd = 16'ha500 + 16'(b * 16 + i);
                pulse(rwr);
            end
        for (b = 0; b < 2; b++)
            for (i = 0; i < 7; i++)
            begin
                bsel = b[0];
                ridx = i[2:0];
                tick;
                `CHK(rd, 16'ha500 + 16'(b * 16 + i))
            end
        $display("test banks done");
        bus = '{1'h1, 20'h00400};
        tick;
        nrst = 1'h0;
        #1;
        `CHK(rg, REGION_NONE)
        `CHK(interrupt_stack_pointer, 16'h0000)
        tick;
        nrst = 1'h1;
        tick;
        tick;
        `CHK(rg, REGION_RAM)
        $display("test midrun reset done");
        report_and_stop;
    end
endmodule // tb_interrupt_flags_address_map

`default_nettype wire
